// ===== design/stopwatch_defines.svh
`ifndef STOPWATCH_DEFINES_SVH
`define STOPWATCH_DEFINES_SVH

// ==========================================================
// register indices, byte address is four times the index
`define SW_IDX_W                 16
`define SW_IDX_PRIORITY_LEVELS   16'hFF20
`define SW_IDX_IRQ_ENABLE_BITS   16'hFF22
`define SW_IDX_IRQ_FACTOR_FLAGS  16'hFF24
`define SW_IDX_CONTROL           16'hFF42
`define SW_IDX_COUNT_BCD         16'hFF43

// ==========================================================
// field positions
`define SW_COUNT_RUN_CONTROL_BIT   0
`define SW_COUNT_CLEAR_STROBE_BIT  1
`define SW_PRIORITY_LOW_BIT        2
`define SW_PRIORITY_HIGH_BIT       3
`define SW_IRQ_FIELD_LSB           4
`define SW_IRQ_FIELD_MSB           6

// ==========================================================
// reset values
`define SW_PRIORITY_RESET  2'h0
`define SW_ENABLE_RESET    3'h0
`define SW_FLAGS_RESET     3'h0
`define SW_RUN_RESET       1'h0
`define SW_DIGIT_RESET     4'h0

// ==========================================================
// counting
`define SW_DIV_STEP   9'h064
`define SW_BCD_LAST   4'h9

`endif

// ===== design/stopwatch_pkg.sv
package stopwatch_pkg;

   // ==========================================================
   // bus answers
   typedef enum logic [1:0] {
      RESP_OKAY   = 2'b00,
      RESP_SLVERR = 2'b10
   } resp_t;

   // ==========================================================
   // state of one decimal digit
   typedef struct packed {
      logic [3:0] value;
   } digit_state_t;

   // ==========================================================
   // state of the timer top
   typedef struct packed {
      logic        awGot;
      logic [15:0] awIdx;
      logic        wGot;
      logic [7:0]  wData;
      logic        wLane0;
      logic        bValid;
      resp_t       bResp;
      logic        rValid;
      logic [7:0]  rData;
      resp_t       rResp;
      logic        tickPrev;
      logic        runReq;
      logic        runActive;
      logic [7:0]  divAcc;
      logic [1:0]  prio;
      logic [2:0]  enable;
      logic [2:0]  flags;
   } sw_state_t;

endpackage

// ===== design/bcd_digit.sv
`timescale 1ns/100ps
`include "stopwatch_defines.svh"

module bcd_digit #(
   parameter logic [3:0] LAST = `SW_BCD_LAST
) (
   // clock and reset
   input  wire logic       core_clk,
   input  wire logic       rst,
   // count control
   input  wire logic       inc,
   input  wire logic       clr,
   // digit out
   output logic [3:0]      value,
   output logic            carry
);

   stopwatch_pkg::digit_state_t q;
   stopwatch_pkg::digit_state_t d;

   // ==========================================================
   // next state
   always_comb begin
      d = q;
      carry = inc && !clr && (q.value == LAST);
      if (clr) begin
         d.value = `SW_DIGIT_RESET;
      end else if (carry) begin
         d.value = `SW_DIGIT_RESET;   // [R3]
      end else if (inc) begin
         d.value = q.value + 4'h1;    // [R3]
      end
   end

   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         q.value <= `SW_DIGIT_RESET;   // [R5]
      end else begin
         q <= d;
      end
   end

   assign value = q.value;

   // ==========================================================
   // checks
   chk_digit_wrap: assert property (   // [R3]
      @(posedge core_clk) disable iff (rst)
      carry |=> (value == 4'h0))
      else $error("digit did not wrap to zero after carry");

endmodule

// ===== design/stopwatch_bcd_timer.sv
// Notes on behaviour
// [R1] fractional divider makes 100 Hz, spacing two or three
// [R2] hundredths carry spacing 25/26, mixed four to six
// [R3] each digit counts zero to nine, carries
// [R4] count register: hundredths low, tenths high, read-only
// [R5] reset clears the count
// [R6] clear bit: one clears count, reads zero
// [R7] cleared while running keeps counting from zero
// [R8] cleared while stopped holds zero
// [R9] run bit starts and stops, reads back
// [R10] stopped count is kept and resumed
// [R11] reset leaves counter stopped
// [R12] run change acts at 256 Hz falling edge
// [R13] stop lets one more count through
// [R14] run bit reads one until halted
// [R15] two-bit priority, zero means no interrupt
// [R16] three enables gate the three interrupts
// [R17] flags set at each divided falling edge
// [R18] flags set regardless of enable, priority
// [R19] request when flag, enable, priority above mask
// [R20] writing one clears a flag
// [R21] cpu clears flag and lowers mask
// [R22] reset clears priority, enables and flags
`timescale 1ns/100ps
`include "stopwatch_defines.svh"

module stopwatch_bcd_timer #(
   parameter int ADDR_W = `SW_IDX_W + 2
) (
   // clock and reset
   input  wire logic              core_clk,
   input  wire logic              rst,
   // 256 Hz tick, synchronous level
   input  wire logic              tick256,
   // cpu side interrupt
   input  wire logic [1:0]        cpuMaskLevel,
   output logic                   irqRequest,
   output logic [1:0]             irqLevel,
   // axi4-lite write address
   input  wire logic              awvalid,
   output logic                   awready,
   input  wire logic [ADDR_W-1:0] awaddr,
   // axi4-lite write data
   input  wire logic              wvalid,
   output logic                   wready,
   input  wire logic [31:0]       wdata,
   input  wire logic [3:0]        wstrb,
   // axi4-lite write response
   output logic                   bvalid,
   input  wire logic              bready,
   output logic [1:0]             bresp,
   // axi4-lite read address
   input  wire logic              arvalid,
   output logic                   arready,
   input  wire logic [ADDR_W-1:0] araddr,
   // axi4-lite read data
   output logic                   rvalid,
   input  wire logic              rready,
   output logic [31:0]            rdata,
   output logic [1:0]             rresp
);

   stopwatch_pkg::sw_state_t q;
   stopwatch_pkg::sw_state_t d;

   logic       fallEdge;
   logic       stepEn;
   logic [8:0] divSum;
   logic       tick100;
   logic       tick10;
   logic       tick1;
   logic       doWrite;
   logic       countClr;
   logic [2:0] flagSet;
   logic [2:0] flagClr;
   logic [3:0] hundredths;
   logic [3:0] tenths;
   logic [7:0] countValue;
   logic [7:0] readValue;
   logic       runRead;

   // ==========================================================
   // register decode
   function automatic logic isMapped(input logic [15:0] idx);
      isMapped = (idx == `SW_IDX_PRIORITY_LEVELS) ||
                 (idx == `SW_IDX_IRQ_ENABLE_BITS) ||
                 (idx == `SW_IDX_IRQ_FACTOR_FLAGS) ||
                 (idx == `SW_IDX_CONTROL) ||
                 (idx == `SW_IDX_COUNT_BCD);
   endfunction

   function automatic logic [7:0] regRead(
      input logic [15:0] idx,
      input logic [1:0]  prio,
      input logic [2:0]  enable,
      input logic [2:0]  flags,
      input logic        run,
      input logic [7:0]  count
   );
      logic [7:0] v;
      v = 8'h00;
      unique case (idx)
         `SW_IDX_PRIORITY_LEVELS:
            v[`SW_PRIORITY_HIGH_BIT:`SW_PRIORITY_LOW_BIT] = prio;
         `SW_IDX_IRQ_ENABLE_BITS:
            v[`SW_IRQ_FIELD_MSB:`SW_IRQ_FIELD_LSB] = enable;
         `SW_IDX_IRQ_FACTOR_FLAGS:
            v[`SW_IRQ_FIELD_MSB:`SW_IRQ_FIELD_LSB] = flags;
         // clear strobe bit stays zero on read
         `SW_IDX_CONTROL:
            v[`SW_COUNT_RUN_CONTROL_BIT] = run;   // [R6] [R9]
         `SW_IDX_COUNT_BCD:
            v = count;
         default:
            v = 8'h00;
      endcase
      regRead = v;
   endfunction

   // ==========================================================
   // count chain
   assign fallEdge = q.tickPrev && !tick256;
   // the last edge taken while active still counts, so a stop
   // request lets exactly one more step through
   assign stepEn   = fallEdge && q.runActive;   // [R12] [R13]
   assign divSum   = {1'b0, q.divAcc} + `SW_DIV_STEP;
   // 100 steps of 256 per second: spacing of 2 or 3 ticks
   assign tick100  = stepEn && divSum[8] && !countClr;   // [R1]

   bcd_digit #(
      .LAST (`SW_BCD_LAST)
   ) u_hundredths (
      .core_clk (core_clk),
      .rst      (rst),
      .inc      (tick100),
      .clr      (countClr),   // [R6]
      .value    (hundredths),
      .carry    (tick10)      // [R2]
   );

   bcd_digit #(
      .LAST (`SW_BCD_LAST)
   ) u_tenths (
      .core_clk (core_clk),
      .rst      (rst),
      .inc      (tick10),
      .clr      (countClr),   // [R6]
      .value    (tenths),
      .carry    (tick1)       // [R2]
   );

   assign countValue = {tenths, hundredths};   // [R4]
   assign runRead    = q.runReq || q.runActive;   // [R14]
   assign readValue  = regRead(araddr[ADDR_W-1:2], q.prio, q.enable,
                               q.flags, runRead, countValue);

   // ==========================================================
   // write commit
   assign doWrite  = q.awGot && q.wGot && !q.bValid;
   assign countClr = doWrite && q.wLane0 &&
                     (q.awIdx == `SW_IDX_CONTROL) &&
                     q.wData[`SW_COUNT_CLEAR_STROBE_BIT];   // [R6]
   assign flagSet  = {tick100, tick10, tick1};   // [R17] [R18]
   assign flagClr  = (doWrite && q.wLane0 &&
                      (q.awIdx == `SW_IDX_IRQ_FACTOR_FLAGS)) ?
                     q.wData[`SW_IRQ_FIELD_MSB:`SW_IRQ_FIELD_LSB] :
                     3'h0;   // [R20]

   // ==========================================================
   // next state
   always_comb begin
      d = q;
      d.tickPrev = tick256;
      // bus write side, address and data in either order
      if (awvalid && awready) begin
         d.awGot = 1'b1;
         d.awIdx = awaddr[ADDR_W-1:2];
      end
      if (wvalid && wready) begin
         d.wGot   = 1'b1;
         d.wData  = wdata[7:0];
         d.wLane0 = wstrb[0];
      end
      if (doWrite) begin
         d.awGot  = 1'b0;
         d.wGot   = 1'b0;
         d.bValid = 1'b1;
         d.bResp  = isMapped(q.awIdx) ? stopwatch_pkg::RESP_OKAY :
                                        stopwatch_pkg::RESP_SLVERR;
         if (q.wLane0) begin
            unique case (q.awIdx)
               `SW_IDX_PRIORITY_LEVELS:
                  d.prio = q.wData[`SW_PRIORITY_HIGH_BIT:
                                   `SW_PRIORITY_LOW_BIT];   // [R15]
               `SW_IDX_IRQ_ENABLE_BITS:
                  d.enable = q.wData[`SW_IRQ_FIELD_MSB:
                                     `SW_IRQ_FIELD_LSB];   // [R16]
               `SW_IDX_CONTROL:
                  d.runReq = q.wData[`SW_COUNT_RUN_CONTROL_BIT];   // [R9]
               // count register ignores writes
               default: begin   // [R4]
               end
            endcase
         end
      end
      if (bvalid && bready) begin
         d.bValid = 1'b0;
      end
      // bus read side
      if (arvalid && arready) begin
         d.rValid = 1'b1;
         d.rData  = readValue;
         d.rResp  = isMapped(araddr[ADDR_W-1:2]) ?
                    stopwatch_pkg::RESP_OKAY :
                    stopwatch_pkg::RESP_SLVERR;
      end else if (rvalid && rready) begin
         d.rValid = 1'b0;
      end
      // run state only moves on the 256 Hz falling edge
      if (fallEdge) begin
         d.runActive = q.runReq;   // [R12] [R13]
      end
      // clear keeps the run state, so a running counter
      // restarts from zero and a stopped one holds zero
      if (countClr) begin
         d.divAcc = 8'h00;   // [R7] [R8]
      end else if (stepEn) begin
         d.divAcc = divSum[7:0];   // [R1] [R10]
      end
      // set beats a clear arriving in the same cycle
      d.flags = (q.flags & ~flagClr) | flagSet;   // [R17] [R20]
   end

   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         q           <= '0;
         q.bResp     <= stopwatch_pkg::RESP_OKAY;
         q.rResp     <= stopwatch_pkg::RESP_OKAY;
         q.runReq    <= `SW_RUN_RESET;        // [R11]
         q.runActive <= `SW_RUN_RESET;        // [R11]
         q.prio      <= `SW_PRIORITY_RESET;   // [R22]
         q.enable    <= `SW_ENABLE_RESET;     // [R22]
         q.flags     <= `SW_FLAGS_RESET;      // [R22]
      end else begin
         q <= d;
      end
   end

   // ==========================================================
   // outputs
   assign awready = !q.awGot && !q.bValid;
   assign wready  = !q.wGot && !q.bValid;
   assign bvalid  = q.bValid;
   assign bresp   = q.bResp;
   assign arready = !q.rValid;
   assign rvalid  = q.rValid;
   assign rresp   = q.rResp;
   assign rdata   = {24'h000000, q.rData};
   // combinational against the mask so a raised mask from the
   // cpu drops the request at once
   assign irqRequest = (|(q.flags & q.enable)) &&
                       (q.prio > cpuMaskLevel);   // [R19] [R21]
   assign irqLevel   = q.prio;   // [R15]

   // ==========================================================
   // checks
   default clocking cb @(posedge core_clk);
   endclocking
   default disable iff (rst);

   chk_clear_count_zero: assert property (   // [R6]
      countClr |=> (countValue == 8'h00))
      else $error("count not zero after clear");

   chk_run_at_edge: assert property (   // [R12]
      !fallEdge |=> $stable(q.runActive))
      else $error("run state moved off the 256 Hz edge");

   chk_stop_reads_one: assert property (   // [R14]
      q.runActive |-> runRead)
      else $error("run bit read zero while still counting");

   chk_stopped_hold: assert property (   // [R10]
      (!q.runActive && !countClr) |=> $stable(countValue))
      else $error("count moved while stopped");

   chk_flag_sets: assert property (   // [R17]
      tick100 |=> q.flags[2])
      else $error("100 Hz flag not set on its event");

   chk_flag_w1c: assert property (   // [R20]
      (flagClr[1] && !flagSet[1]) |=> !q.flags[1])
      else $error("10 Hz flag survived a write of one");

   chk_irq_above_mask: assert property (   // [R19]
      irqRequest |-> (q.prio > cpuMaskLevel) &&
                     (|(q.flags & q.enable)))
      else $error("request without cause");

   chk_prio_zero_quiet: assert property (   // [R15]
      (q.prio == 2'h0) |-> !irqRequest)
      else $error("request at priority zero");

   chk_digits_bcd: assert property (   // [R3]
      (hundredths <= 4'h9) && (tenths <= 4'h9))
      else $error("digit outside zero to nine");

   chk_stop_one_more: assert property (   // [R13]
      (fallEdge && q.runActive && !q.runReq) |->
      ##1 !q.runActive)
      else $error("stop did not halt after the last step");

   chk_ten_flag_sets: assert property (   // [R17] [R18]
      tick10 |=> q.flags[1])
      else $error("10 Hz flag not set on its event");

   chk_one_flag_sets: assert property (   // [R17] [R18]
      tick1 |=> q.flags[0])
      else $error("1 Hz flag not set on its event");

   chk_tick_gap_min: assert property (   // [R1]
      tick100 |=> (q.divAcc < 8'h64))
      else $error("remainder after a tick too large");

   chk_clear_keeps_run: assert property (   // [R7]
      (countClr && q.runActive && !fallEdge) |=>
      q.runActive)
      else $error("clear stopped a running counter");

   chk_mask_blocks: assert property (   // [R19]
      (cpuMaskLevel >= q.prio) |-> !irqRequest)
      else $error("request at or below the mask level");

   chk_clear_reads_zero: assert property (   // [R6]
      (arvalid && arready &&
       (araddr[ADDR_W-1:2] == `SW_IDX_CONTROL)) |=>
      !rdata[`SW_COUNT_CLEAR_STROBE_BIT])
      else $error("clear bit read back as one");

   chk_reset_clears: assert property (   // [R5] [R22]
      disable iff (1'b0)
      rst |-> (countValue == 8'h00) && (q.prio == 2'h0) &&
              (q.enable == 3'h0) && (q.flags == 3'h0))
      else $error("state not cleared under reset");

endmodule

// ===== sim/cpu_core_model.sv
`timescale 1ns/100ps

module cpu_core_model #(
   parameter int HALF = 8
) (
   // clock and reset
   input  wire logic       core_clk,
   input  wire logic       rst,
   // interrupt from the timer
   input  wire logic       irqRequest,
   input  wire logic [1:0] irqLevel,
   // software side
   input  wire logic [1:0] baseMask,
   input  wire logic       returnFromException,
   // towards the timer
   output logic            tick256,
   output logic [1:0]      cpuMaskLevel
);
   // ==========
   // divided tick, runs free once out of reset
   logic [7:0] tickCnt_q;
   logic       tick_q;

   assign tick256 = tick_q;

   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         tickCnt_q <= 8'h00;
         tick_q    <= 1'b1;
      end else if (tickCnt_q == 8'(HALF - 1)) begin
         tickCnt_q <= 8'h00;
         tick_q    <= ~tick_q;
      end else begin
         tickCnt_q <= tickCnt_q + 8'h01;
      end
   end

   // ==========
   // taking a request raises the mask to its level
   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         cpuMaskLevel <= 2'h0;
      end else if (irqRequest) begin
         cpuMaskLevel <= irqLevel;
      end else if (returnFromException) begin
         cpuMaskLevel <= baseMask;
      end
   end
endmodule

// ===== sim/stopwatch_bcd_timer_bench.sv
`timescale 1ns/100ps
`include "stopwatch_defines.svh"

module stopwatch_bcd_timer_bench;
   // ==========
   // stimulus and observed signals
   logic        core_clk = 1'b0;
   logic        rst      = 1'b0;
   logic        awvalid  = 1'b0;
   logic        wvalid   = 1'b0;
   logic        arvalid  = 1'b0;
   logic        bready   = 1'b1;
   logic        rready   = 1'b1;
   logic [17:0] awaddr   = 18'h00000;
   logic [17:0] araddr   = 18'h00000;
   logic [31:0] wdata    = 32'h00000000;
   logic [3:0]  wstrb    = 4'hF;
   logic [1:0]  baseMask = 2'h0;
   logic        ret      = 1'b0;
   logic        awready, wready, bvalid, arready, rvalid;
   logic        tick256, irqRequest;
   logic [1:0]  bresp, rresp, irqLevel, cpuMaskLevel;
   logic [31:0] rdata, rdv;
   logic [1:0]  rrv, brv;
   int          numErrors = 0;
   int          nTests    = 0;

   localparam logic [17:0] A_PRI = {`SW_IDX_PRIORITY_LEVELS, 2'b00};
   localparam logic [17:0] A_ENA = {`SW_IDX_IRQ_ENABLE_BITS, 2'b00};
   localparam logic [17:0] A_FLG = {`SW_IDX_IRQ_FACTOR_FLAGS, 2'b00};
   localparam logic [17:0] A_CTL = {`SW_IDX_CONTROL, 2'b00};
   localparam logic [17:0] A_CNT = {`SW_IDX_COUNT_BCD, 2'b00};
   localparam logic [17:0] A_BAD = 18'h3FCC0;

   stopwatch_bcd_timer stopwatch_bcd_timer_inst (.core_clk, .rst,
      .tick256, .cpuMaskLevel, .irqRequest, .irqLevel, .awvalid,
      .awready, .awaddr, .wvalid, .wready, .wdata, .wstrb, .bvalid,
      .bready, .bresp, .arvalid, .arready, .araddr, .rvalid, .rready,
      .rdata, .rresp);

   cpu_core_model #(.HALF(8)) cpu_core_model_inst (.core_clk, .rst,
      .irqRequest, .irqLevel, .baseMask, .returnFromException(ret),
      .tick256, .cpuMaskLevel);

   initial forever #5 core_clk = ~core_clk;

   // ==========
   // checking and ending
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      nTests++;
      if (seen !== exp) begin
         numErrors++;
         $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
      end
   endtask

   task automatic report_and_stop();
      $display("mismatches %0d comparisons %0d", numErrors, nTests);
      if (numErrors == 0 && nTests > 0) begin
         $display("ALL CHECKS OK");
      end else begin
         $display("CHECKS NOT OK");
      end
      $finish;
   endtask

   // ==========
   // bus cycles, ready strobes held high throughout
   task automatic wr(input logic [17:0] a, input logic [7:0] d);
      int t;
      t = 0;
      awaddr  <= a;
      wdata   <= {24'h000000, d};
      awvalid <= 1'b1;
      wvalid  <= 1'b1;
      do begin
         @(posedge core_clk);
         t++;
         if (awready) awvalid <= 1'b0;
         if (wready) wvalid <= 1'b0;
      end while (!bvalid && t < 50);
      if (!bvalid) check(32'h0, 32'h1);
      brv = bresp;
   endtask

   task automatic rd(input logic [17:0] a);
      int t;
      t = 0;
      araddr  <= a;
      arvalid <= 1'b1;
      do begin
         @(posedge core_clk);
         t++;
         if (arready) arvalid <= 1'b0;
      end while (!rvalid && t < 50);
      if (!rvalid) check(32'h0, 32'h1);
      rdv = rdata;
      rrv = rresp;
   endtask

   task automatic expect_reg(input logic [17:0] a, input logic [7:0] e);
      rd(a);
      check(rdv, {24'h000000, e});
      check({30'h0, rrv}, {30'h0, stopwatch_pkg::RESP_OKAY});
   endtask

   // one more design sample after each falling tick edge
   task automatic edges(input int n);
      repeat (n) begin
         @(negedge tick256);
         @(posedge core_clk);
      end
   endtask

   task automatic start_run(input int n);
      edges(1);
      wr(A_CTL, 8'h01);
      edges(n);
   endtask

   task automatic stop_run();
      wr(A_CTL, 8'h00);
      expect_reg(A_CTL, 8'h01);
      edges(1);
      expect_reg(A_CTL, 8'h00);
   endtask

   task automatic leave_irq();
      ret <= 1'b1;
      @(posedge core_clk);
      ret <= 1'b0;
      repeat (3) @(posedge core_clk);
   endtask

   // ==========
   // hang guard, whole run is some 6000 cycles
   initial begin
      repeat (20000) @(posedge core_clk);
      numErrors++;
      report_and_stop();
   end

   initial begin
      rst <= 1'b1;
      repeat (6) @(posedge core_clk);
      rst <= 1'b0;
      @(posedge core_clk);
      expect_reg(A_PRI, 8'h00);
      expect_reg(A_ENA, 8'h00);
      expect_reg(A_FLG, 8'h00);
      expect_reg(A_CTL, 8'h00);
      expect_reg(A_CNT, 8'h00);
      rd(A_BAD);
      check({30'h0, rrv}, {30'h0, stopwatch_pkg::RESP_SLVERR});
      check(rdv, 32'h0);
      wr(A_BAD, 8'hFF);
      check({30'h0, brv}, {30'h0, stopwatch_pkg::RESP_SLVERR});
      wr(A_PRI, 8'h0C);
      expect_reg(A_PRI, 8'h0C);
      // lane 0 strobe low leaves the register alone
      wstrb <= 4'h0;
      wr(A_PRI, 8'h04);
      wstrb <= 4'hF;
      expect_reg(A_PRI, 8'h0C);
      wr(A_ENA, 8'h70);
      expect_reg(A_ENA, 8'h70);
      wr(A_ENA, 8'h00);
      wr(A_CNT, 8'h99);
      check({30'h0, brv}, {30'h0, stopwatch_pkg::RESP_OKAY});
      expect_reg(A_CNT, 8'h00);
      // 64 steps of 100/256 give exactly 25 hundredths
      start_run(64);
      stop_run();
      expect_reg(A_CNT, 8'h25);
      expect_reg(A_FLG, 8'h60);
      edges(10);
      expect_reg(A_CNT, 8'h25);
      wr(A_FLG, 8'h00);
      expect_reg(A_FLG, 8'h60);
      wr(A_FLG, 8'h20);
      expect_reg(A_FLG, 8'h40);
      wr(A_CTL, 8'h02);
      expect_reg(A_CTL, 8'h00);
      edges(5);
      expect_reg(A_CNT, 8'h00);
      // clear in mid-run, 64 steps follow it
      start_run(10);
      wr(A_CTL, 8'h03);
      edges(63);
      stop_run();
      expect_reg(A_CNT, 8'h25);
      start_run(64);
      stop_run();
      expect_reg(A_CNT, 8'h50);
      start_run(128);
      stop_run();
      expect_reg(A_CNT, 8'h00);
      expect_reg(A_FLG, 8'h70);
      check({30'h0, cpuMaskLevel}, 32'h0);
      check({31'h0, irqRequest}, 32'h0);
      // priority 2 against mask 0, then held by mask 2
      baseMask <= 2'h1;
      wr(A_PRI, 8'h08);
      wr(A_ENA, 8'h70);
      check({31'h0, irqRequest}, 32'h1);
      // model takes the request at this edge, mask lands after it
      repeat (2) @(posedge core_clk);
      check({30'h0, cpuMaskLevel}, 32'h2);
      check({31'h0, irqRequest}, 32'h0);
      check({30'h0, irqLevel}, 32'h2);
      leave_irq();
      check({30'h0, cpuMaskLevel}, 32'h2);
      wr(A_FLG, 8'h70);
      expect_reg(A_FLG, 8'h00);
      leave_irq();
      check({30'h0, cpuMaskLevel}, 32'h1);
      check({31'h0, irqRequest}, 32'h0);
      report_and_stop();
   end
endmodule
